// file: fabd_pkg.sv
// Package of encodings and widths for the file-register ALU and bit-test decoder
package fabd_pkg;
  // ==========================================================================
  // Instruction word layout
  // ==========================================================================
  localparam int INSN_W = 14;        // Instruction word width
  localparam int DATA_W = 8;         // File register and accumulator width
  localparam int ADDR_W = 7;         // File address width
  localparam int BITP_W = 3;         // Bit position width
  localparam int DEST_POS = 7;       // Destination select bit
  localparam int BITP_LSB = 7;       // Low bit of the bit position field
  // Opcode fields
  localparam logic [5:0] OP_ADD_ACC_TO_REG = 6'h07;   // 00 0111
  localparam logic [5:0] OP_AND_ACC_WITH_REG = 6'h05; // 00 0101
  localparam logic [3:0] OP_CLEAR_REG_BIT = 4'h4;     // 01 00
  localparam logic [3:0] OP_TEST_BIT_SKIP = 4'h6;     // 01 10
  // Status flag positions in the flag bus
  localparam int FLAG_C = 0;         // Carry
  localparam int FLAG_DC = 1;        // Digit carry
  localparam int FLAG_Z = 2;         // Zero
  // Reset value of the skip state
  localparam logic SKIP_RST = 1'b0;

  // Execution phase
  typedef enum logic
  {
    FABD_EXEC = 1'b0,                // Normal one-cycle execution
    FABD_NOP = 1'b1                  // Discarded slot run as no-operation
  } fabd_phase_t;
endpackage

// file: fabd_core.sv
// Decoder and executor for register add, AND, bit clear and bit test-skip
//
// Summary of operation
// - Add opcode sums accumulator and register, sets C DC Z
// - Destination zero writes accumulator, register unchanged
// - Destination one writes result back to register
// - AND opcode ANDs, routes result, updates zero only
// - Clear tested bit discards next, runs no-operation
// - Skip takes two cycles, second is no-operation
// - Port read-modify-write uses pin levels as operand
module fabd_core
  import fabd_pkg::*;
(
  input wire logic clk_i,                                // Core clock
  input wire logic reset_n_i,                            // Synchronous reset, active low
  input wire logic insn_valid_i,                         // Fetched word is present
  input wire logic [fabd_pkg::INSN_W-1:0] insn_i,        // Fetched instruction word
  input wire logic [fabd_pkg::DATA_W-1:0] reg_rdata_i,   // File register contents
  input wire logic reg_is_port_i,                        // Addressed register is an I/O port
  input wire logic [fabd_pkg::DATA_W-1:0] port_pins_i,   // Pin levels of that port
  output logic [fabd_pkg::ADDR_W-1:0] reg_addr_o,        // File address being read
  output logic reg_we_o,                                 // File register write strobe
  output logic [fabd_pkg::ADDR_W-1:0] reg_waddr_o,       // File register write address
  output logic [fabd_pkg::DATA_W-1:0] reg_wdata_o,       // File register write data
  output logic [fabd_pkg::DATA_W-1:0] acc_o,             // Accumulator
  output logic [2:0] flags_o,                            // Z, DC, C flags
  output logic nop_cycle_o,                              // Current slot runs as no-operation
  output logic insn_done_o                               // Decoded instruction retired
);
  import fabd_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================
  // The word after a taken skip is already fetched; gating every decode with
  // the phase keeps that word from touching any state but waddr_q, which still loads its address.
  // Bit operations share the upper four opcode bits; add and AND use six.
  logic is_add;                      // Add accumulator to register
  logic is_and;                      // AND accumulator with register
  logic is_bclr;                     // Clear register bit
  logic is_btst;                     // Test bit, skip if zero
  logic dest;                        // Destination select
  logic [BITP_W-1:0] bitp;           // Bit position
  logic [DATA_W-1:0] operand;        // Register operand
  fabd_phase_t phase_q, phase_d;     // Execution phase

  // Field extraction; a slot marked no-operation decodes to nothing
  always_comb
  begin
    dest = insn_i[DEST_POS];
    bitp = insn_i[BITP_LSB +: BITP_W];
    is_add = insn_valid_i && (phase_q == FABD_EXEC) && (insn_i[13:8] == OP_ADD_ACC_TO_REG);
    is_and = insn_valid_i && (phase_q == FABD_EXEC) && (insn_i[13:8] == OP_AND_ACC_WITH_REG);
    is_bclr = insn_valid_i && (phase_q == FABD_EXEC) && (insn_i[13:10] == OP_CLEAR_REG_BIT);
    is_btst = insn_valid_i && (phase_q == FABD_EXEC) && (insn_i[13:10] == OP_TEST_BIT_SKIP);
    // Port registers modified from themselves read the pins
    operand = reg_is_port_i ? port_pins_i : reg_rdata_i;
  end

  // Read address comes straight from the word so the operand arrives this cycle
  assign reg_addr_o = insn_i[ADDR_W-1:0];

  // ==========================================================================
  // Datapath and state
  // ==========================================================================
  // The register write is registered, so it reaches the file one cycle after
  // execute; the core does not forward it to a next word that reads that address.
  logic [DATA_W-1:0] acc_q, acc_d;       // Accumulator
  logic [2:0] flags_q, flags_d;          // Status flags
  logic we_q, we_d;                      // Registered write strobe
  logic [ADDR_W-1:0] waddr_q, waddr_d;   // Registered write address
  logic [DATA_W-1:0] wdata_q, wdata_d;   // Registered write data
  logic done_q, done_d;                  // Retire pulse
  logic [DATA_W:0] sum;                  // Full add with carry
  logic [4:0] nib_sum;                   // Low nibble add for digit carry
  logic [DATA_W-1:0] result;             // ALU result

  // Next-state computation
  always_comb
  begin
    sum = {1'b0, acc_q} + {1'b0, operand};
    nib_sum = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]};
    result = is_add ? sum[DATA_W-1:0] : (acc_q & operand);
    acc_d = acc_q;
    flags_d = flags_q;
    we_d = 1'b0;
    waddr_d = reg_addr_o;
    wdata_d = wdata_q;
    phase_d = FABD_EXEC;
    done_d = 1'b0;
    if (is_add || is_and)
    begin
      done_d = 1'b1;
      // Destination routing
      if (dest)
      begin
        we_d = 1'b1;
        wdata_d = result;
      end
      else
      begin
        acc_d = result;
      end
      flags_d[FLAG_Z] = (result == '0);
      if (is_add)
      begin
        flags_d[FLAG_C] = sum[DATA_W];
        flags_d[FLAG_DC] = nib_sum[4];
      end
    end
    else if (is_bclr)
    begin
      // Single bit cleared, flags untouched
      done_d = 1'b1;
      we_d = 1'b1;
      wdata_d = operand & ~(8'h01 << bitp);
    end
    else if (is_btst)
    begin
      done_d = 1'b1;
      // A clear bit turns the next slot into a no-operation
      if (!operand[bitp])
      begin
        phase_d = FABD_NOP;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      acc_q <= 8'h00;
      flags_q <= 3'h0;
      we_q <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
      done_q <= 1'b0;
      phase_q <= FABD_EXEC;
    end
    else
    begin
      acc_q <= acc_d;
      flags_q <= flags_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      done_q <= done_d;
      phase_q <= phase_d;
    end
  end

  // Outputs straight from the registers
  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign reg_we_o = we_q;
  assign reg_waddr_o = waddr_q;
  assign reg_wdata_o = wdata_q;
  assign nop_cycle_o = (phase_q == FABD_NOP);
  assign insn_done_o = done_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Each property looks one cycle after the decode that triggers it, since
  // every result is registered.
  AST_ADD_SUM: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_add && !dest |=> acc_o == $past(sum[7:0]) && flags_o[FLAG_C] == $past(sum[8]))
    else $error("add result or carry wrong");
  AST_DEST_ACC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (is_add || is_and) && !dest |=> !reg_we_o)
    else $error("accumulator destination wrote register");
  AST_DEST_REG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (is_add || is_and) && dest |=> reg_we_o && reg_wdata_o == $past(result) && $stable(acc_o))
    else $error("register destination wrong");
  AST_AND_FLAGS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_and |=> flags_o[1:0] == $past(flags_o[1:0]) && flags_o[FLAG_Z] == ($past(result) == 8'h00))
    else $error("AND touched carry flags");
  AST_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_btst && !operand[bitp] |=> (nop_cycle_o && insn_done_o) ##1 (!nop_cycle_o && !insn_done_o))
    else $error("skip not taken as one no-operation slot");
  AST_NO_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_btst && operand[bitp] |=> !nop_cycle_o && $stable(flags_o))
    else $error("set bit caused skip");
  AST_BCLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_bclr |=> reg_we_o && !reg_wdata_o[$past(bitp)] && $stable(flags_o))
    else $error("bit clear wrong");
  AST_NOP_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    nop_cycle_o |=> !reg_we_o && $stable(acc_o) && $stable(flags_o))
    else $error("no-operation slot changed state");
  AST_PIN_OPERAND: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_bclr && reg_is_port_i |=> reg_wdata_o == ($past(port_pins_i) & ~(8'h01 << $past(bitp))))
    else $error("port operand not from pins");

  // Further checks on datapath details
  // Add reports the low-nibble carry and a zero result
  AST_ADD_FLAGS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_add |=> flags_o[FLAG_Z] == ($past(acc_o + operand) == 8'h00) && flags_o[FLAG_DC] ==
      (({1'b0, $past(acc_o[3:0])} + {1'b0, $past(operand[3:0])}) > 5'h0F))
    else $error("add zero or digit carry wrong");
  // AND into the accumulator holds the bitwise product
  AST_AND_ROUTE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_and && !dest |=> acc_o == ($past(acc_o) & $past(operand)))
    else $error("AND result wrong");
  // Register writes go to the address that was read
  AST_WADDR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (is_bclr || ((is_add || is_and) && dest)) |=> reg_waddr_o == $past(reg_addr_o))
    else $error("write address wrong");
  // Bit test writes nothing and changes no flag
  AST_TEST_QUIET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_btst |=> !reg_we_o && $stable(acc_o) && $stable(flags_o))
    else $error("bit test changed state");
  // Bit clear keeps every other bit of the operand
  AST_BCLR_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_bclr |=> (reg_wdata_o | (8'h01 << $past(bitp))) ==
      ($past(operand) | (8'h01 << $past(bitp))))
    else $error("bit clear disturbed other bits");
  // The discarded slot lasts one cycle and retires nothing
  AST_NOP_ONE_SLOT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    nop_cycle_o |=> !nop_cycle_o && !insn_done_o)
    else $error("no-operation slot too long");
endmodule

// file: fabd_core_tb_top.sv
// Self-checking testbench for the file-register ALU and bit-test decoder
module fabd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fabd_pkg::*;
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic clk_i = 1'b0; // Core clock, 8 ns period
  logic reset_n_i = 1'b0; // Held low for two edges
  logic insn_valid_i = 1'b0;
  logic [INSN_W-1:0] insn_i = '0;
  logic [DATA_W-1:0] reg_rdata_i = '0;
  logic reg_is_port_i = 1'b0;
  logic [DATA_W-1:0] port_pins_i = '0;
  logic [ADDR_W-1:0] reg_addr_o, reg_waddr_o;
  logic reg_we_o, nop_cycle_o, insn_done_o;
  logic [DATA_W-1:0] reg_wdata_o, acc_o;
  logic [2:0] flags_o;
  int n_mismatch = 0; // Mismatches seen
  int comparisons = 0; // Comparisons made
  int cycles = 0; // Cycle counter for the hang guard
  always #4 clk_i = ~clk_i;
  fabd_core i_fabd_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .reg_rdata_i(reg_rdata_i), .reg_is_port_i(reg_is_port_i),
    .port_pins_i(port_pins_i), .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o),
    .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o), .acc_o(acc_o), .flags_o(flags_o),
    .nop_cycle_o(nop_cycle_o), .insn_done_o(insn_done_o));
  // ==========================================================================
  // Drivers
  // ==========================================================================
  // Presents one word for one edge, then waits until its results have settled
  task automatic send(input logic [INSN_W-1:0] w, input logic [DATA_W-1:0] r);
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= w;
    reg_rdata_i <= r;
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask
  // Checks the retirement signals common to every executed word
  task automatic chk_out(input logic we, input logic [7:0] wd, input logic [7:0] ac,
    input logic [2:0] fl, input logic no_operation);
    `CHK("write strobe", we, reg_we_o)
    if (we) `CHK("write data", wd, reg_wdata_o)
    `CHK("accumulator", ac, acc_o)
    `CHK("flags", fl, flags_o)
    `CHK("discard slot", no_operation, nop_cycle_o)
    `CHK("retired", 1'b1, insn_done_o)
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Add into the accumulator, into the register, then with full carry out
  task automatic t_add();
    send({OP_ADD_ACC_TO_REG, 1'b0, 7'h11}, 8'h17);
    chk_out(1'b0, 8'h00, 8'h17, 3'b000, 1'b0);
    `CHK("read address", 7'h11, reg_addr_o)
    send({OP_ADD_ACC_TO_REG, 1'b1, 7'h04}, 8'hC2);
    chk_out(1'b1, 8'hD9, 8'h17, 3'b000, 1'b0);
    `CHK("write address", 7'h04, reg_waddr_o)
    send({OP_ADD_ACC_TO_REG, 1'b0, 7'h7F}, 8'hE9);
    chk_out(1'b0, 8'h00, 8'h00, 3'b111, 1'b0);
  endtask
  // AND touches only the zero flag; carries set beforehand must survive
  task automatic t_and();
    send({OP_ADD_ACC_TO_REG, 1'b0, 7'h01}, 8'h16);
    send({OP_ADD_ACC_TO_REG, 1'b0, 7'h01}, 8'hFF);
    chk_out(1'b0, 8'h00, 8'h15, 3'b011, 1'b0);
    send({OP_AND_ACC_WITH_REG, 1'b1, 7'h04}, 8'h34);
    chk_out(1'b1, 8'h14, 8'h15, 3'b011, 1'b0);
    send({OP_AND_ACC_WITH_REG, 1'b0, 7'h05}, 8'hEA);
    chk_out(1'b0, 8'h00, 8'h00, 3'b111, 1'b0);
  endtask
  // Bit clear at both ends of the bit field, flags left alone
  task automatic t_clr();
    send({OP_CLEAR_REG_BIT, 3'd7, 7'h0C}, 8'hC7);
    chk_out(1'b1, 8'h47, 8'h00, 3'b111, 1'b0);
    send({OP_CLEAR_REG_BIT, 3'd0, 7'h00}, 8'hFF);
    chk_out(1'b1, 8'hFE, 8'h00, 3'b111, 1'b0);
    `CHK("write address", 7'h00, reg_waddr_o)
  endtask
  // Taken skip discards the following word; untaken skip costs one cycle
  task automatic t_skip();
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= {OP_TEST_BIT_SKIP, 3'd3, 7'h20};
    reg_rdata_i <= 8'hF7;
    @(posedge clk_i);
    insn_i <= {OP_CLEAR_REG_BIT, 3'd0, 7'h21};
    reg_rdata_i <= 8'hFF;
    #1;
    chk_out(1'b0, 8'h00, 8'h00, 3'b111, 1'b1);
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    #1;
    `CHK("ignored word strobe", 1'b0, reg_we_o)
    `CHK("ignored word retired", 1'b0, insn_done_o)
    `CHK("slot over", 1'b0, nop_cycle_o)
    send({OP_TEST_BIT_SKIP, 3'd3, 7'h20}, 8'h08);
    chk_out(1'b0, 8'h00, 8'h00, 3'b111, 1'b0);
  endtask
  // Port operands come from the pins, not from the latch contents
  task automatic t_port();
    @(posedge clk_i);
    reg_is_port_i <= 1'b1;
    port_pins_i <= 8'h0F;
    send({OP_CLEAR_REG_BIT, 3'd0, 7'h06}, 8'hF0);
    chk_out(1'b1, 8'h0E, 8'h00, 3'b111, 1'b0);
    @(posedge clk_i);
    reg_is_port_i <= 1'b0;
  endtask
  // ==========================================================================
  // Verdict, hang guard and main sequence
  // ==========================================================================
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short far beyond the few dozen cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_add();
    t_and();
    t_clr();
    t_skip();
    t_port();
    complete_run();
  end
endmodule
